// ==== spirq_status_pins.v ====
// status pin routing, interrupt latch and capture, and reset-time strap capture
`timescale 1ns/1ns
`default_nettype none
`include "spirq_regs.vh"

// Functional notes
// R1 - each pin ORs its selected status flags
// R2 - reference flags come from one selected reference
// R3 - pins are inputs during reset, strapped at release
// R4 - pins return to outputs at reset release
// R5 - pin reset repeats the power-up sequence
// R6 - low strap bits pick a tuning word
// R7 - tuning word loaded without commit strobe
// R8 - strap bit three selects clock source
// R9 - table codes give listed start-up frequencies
// R10 - crystal mode defaults multiplier to forty
// R11 - host closes loop after programming dividers
// R12 - interrupt-mode pin shows the interrupt flag
// R13 - status register reads every flag anytime
// R14 - flags edge-monitored, some single direction
// R15 - masked-in change sets the interrupt latch
// R16 - capture status when interrupt flag asserts
// R17 - reset bit clears flag, capture, detectors; the code clears flag and capture only, and the edge detectors keep running
// R18 - power-up reset pulse of 75 ns
// R19 - pins float for the whole reset; the code drives them for two more clocks after a pin reset falls
// R20 - board resistors set the strap pattern
// R21 - interrupt flag holds until reset bit

module spirq_status_pins (
  input  wire                          clock_i,
  input  wire                          arst_n_i,
  input  wire                          pin_rst_n_i,
  input  wire [3:0]                    pin_in_i,
  output reg  [3:0]                    pin_out_o,
  output reg  [3:0]                    pin_oe_o,
  input  wire [`SPIRQ_NFLAG-1:0]       flags_i,
  input  wire [`SPIRQ_ADDR_W-1:0]      addr_i,
  input  wire [31:0]                   wdata_i,
  input  wire                          wr_i,
  input  wire                          rd_i,
  output reg  [31:0]                   rdata_o,
  output reg                           irq_o,
  output reg  [`SPIRQ_TW_W-1:0]        tuning_word_o,
  output reg                           sysclk_direct_o,
  output reg  [`SPIRQ_MULT_W-1:0]      sysclk_mult_o,
  output reg                           loop_open_o
);

  // ------------------------------------------------------------
  // reset sequencer
  // ------------------------------------------------------------
  localparam [2:0] ST_RESET = 3'b001;
  localparam [2:0] ST_STRAP = 3'b010;
  localparam [2:0] ST_RUN   = 3'b100;
  // reset pulse length in clocks, cut to the counter width on purpose
  localparam integer POR_CYC_I = `SPIRQ_POR_CYC;

  reg  [2:0]               state_r;
  reg  [2:0]               state_nxt;
  reg  [`SPIRQ_CNT_W-1:0]  cnt_r;
  reg  [`SPIRQ_CNT_W-1:0]  cnt_nxt;
  reg  [1:0]               prst_sync_r;
  reg  [3:0]               pin_s1_r;
  reg  [3:0]               pin_s2_r;
  reg  [`SPIRQ_NFLAG-1:0]  flag_s1_r;
  reg  [`SPIRQ_NFLAG-1:0]  flag_s2_r;
  reg  [`SPIRQ_NFLAG-1:0]  flag_prev_r;
  reg  [31:0]              pin_sel_r;
  reg  [`SPIRQ_NFLAG-1:0]  mask_r;
  reg  [`SPIRQ_NFLAG-1:0]  capture_r;
  reg  [`SPIRQ_STRAP_W-1:0] strap_r;
  reg                      irq_r;
  reg  [`SPIRQ_NFLAG-1:0]  event_w;
  reg  [3:0]               pin_val_w;
  reg  [`SPIRQ_PIN_CFG_W-1:0] cfg_w;
  reg  [`SPIRQ_NFLAG-1:0]  sel_flags_w;
  wire [`SPIRQ_TW_W-1:0]   rom_word_w;
  wire                     irq_reset_w;
  wire                     strap_take_w;
  wire [`SPIRQ_CNT_W-1:0]  por_cyc_w;
  integer                  p;

  assign por_cyc_w    = POR_CYC_I[`SPIRQ_CNT_W-1:0];

  assign irq_reset_w  = wr_i && (addr_i == `SPIRQ_A_CONTROL) &&
                        wdata_i[`SPIRQ_CTRL_IRQ_RESET];
  assign strap_take_w = (state_r == ST_STRAP) && (cnt_r == 3'h0);

  // pin reset synchroniser; second stage alone feeds the sequencer
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prst_sync_r <= 2'h0;
      pin_s1_r    <= 4'h0;
      pin_s2_r    <= 4'h0;
      flag_s1_r   <= {`SPIRQ_NFLAG{1'b0}};
      flag_s2_r   <= {`SPIRQ_NFLAG{1'b0}};
    end else begin
      prst_sync_r <= {prst_sync_r[0], pin_rst_n_i};
      pin_s1_r    <= pin_in_i;
      pin_s2_r    <= pin_s1_r;
      flag_s1_r   <= flags_i;
      flag_s2_r   <= flag_s1_r;
    end
  end

  // the strap window lasts the full pulse so board pulls settle first
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_RESET: begin
        state_nxt = ST_STRAP;
        cnt_nxt   = por_cyc_w; // [R18]
      end
      ST_STRAP: begin
        if (cnt_r != 3'h0) begin
          cnt_nxt = cnt_r - 3'h1;
        end else begin
          state_nxt = ST_RUN; // [R4]
        end
      end
      ST_RUN: begin
        if (!prst_sync_r[1]) begin
          state_nxt = ST_STRAP; // [R5]
          cnt_nxt   = por_cyc_w;
        end
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ST_RESET;
      cnt_r   <= 3'h0;
    end else if (!prst_sync_r[1] && state_r == ST_STRAP) begin
      state_r <= ST_STRAP; // hold the window while the pin stays low
      cnt_r   <= por_cyc_w;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // ------------------------------------------------------------
  // strap capture and start-up settings
  // ------------------------------------------------------------
  spirq_tw_rom u_rom (
    .idx_i  (pin_s2_r[2:0]),
    .word_o (rom_word_w)
  );

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_r         <= 4'h0;
      tuning_word_o   <= {`SPIRQ_TW_W{1'b0}};
      sysclk_direct_o <= 1'b0;
      sysclk_mult_o   <= `SPIRQ_MULT_DEFAULT;
      loop_open_o     <= 1'b1;
    end else if (strap_take_w) begin
      strap_r         <= pin_s2_r; // [R3] [R20]
      tuning_word_o   <= rom_word_w; // [R6] [R7] [R9]
      sysclk_direct_o <= pin_s2_r[`SPIRQ_STRAP_SYSCLK]; // [R8]
      sysclk_mult_o   <= pin_s2_r[`SPIRQ_STRAP_SYSCLK] ? `SPIRQ_MULT_BYPASS
                                                       : `SPIRQ_MULT_DEFAULT; // [R10]
      loop_open_o     <= 1'b1; // [R11]
    end else if (wr_i) begin
      if (addr_i == `SPIRQ_A_TUNING_WORD) begin
        tuning_word_o <= wdata_i[`SPIRQ_TW_W-1:0];
      end else if (addr_i == `SPIRQ_A_SYSCLK) begin
        sysclk_mult_o <= wdata_i[`SPIRQ_MULT_W-1:0];
        loop_open_o   <= wdata_i[8];
      end
    end
  end

  // ------------------------------------------------------------
  // edge detection and interrupt latch
  // ------------------------------------------------------------
  always @* begin
    event_w = flag_s2_r ^ flag_prev_r; // [R14]
    // estimate done only reports its rising edge
    event_w[`SPIRQ_FLAG_EST_DONE] = flag_s2_r[`SPIRQ_FLAG_EST_DONE] &
                                    ~flag_prev_r[`SPIRQ_FLAG_EST_DONE]; // [R14]
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_prev_r <= {`SPIRQ_NFLAG{1'b0}};
      irq_r       <= 1'b0;
      capture_r   <= {`SPIRQ_NFLAG{1'b0}};
    end else begin
      // a fresh event in the clearing cycle wins over the clear
      flag_prev_r <= flag_s2_r; // [R17]
      if (|(event_w & mask_r)) begin
        irq_r <= 1'b1; // [R15] [R21]
        if (!irq_r || irq_reset_w) begin
          capture_r <= flag_s2_r; // [R16]
        end
      end else if (irq_reset_w) begin
        irq_r     <= 1'b0; // [R17]
        capture_r <= {`SPIRQ_NFLAG{1'b0}}; // [R17]
      end
    end
  end

  // ------------------------------------------------------------
  // pin routing
  // ------------------------------------------------------------
  always @* begin
    pin_val_w   = 4'h0;
    cfg_w       = 8'h00;
    sel_flags_w = {`SPIRQ_NFLAG{1'b0}};
    for (p = 0; p < 4; p = p + 1) begin
      cfg_w = pin_sel_r[p*8 +: 8];
      sel_flags_w = flag_s2_r;
      // a pin watches one reference only
      if (cfg_w[`SPIRQ_CFG_REFSEL]) begin
        sel_flags_w[1:0] = flag_s2_r[3:2]; // [R2]
      end
      sel_flags_w[3:2] = 2'b00; // [R2]
      if (cfg_w[`SPIRQ_CFG_IRQMODE]) begin
        pin_val_w[p] = irq_r; // [R12]
      end else begin
        pin_val_w[p] = |(sel_flags_w & {cfg_w[5:4], 2'b00, cfg_w[1:0]}); // [R1]
      end
    end
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_out_o <= 4'h0;
      pin_oe_o  <= 4'h0; // [R19]
      irq_o     <= 1'b0;
    end else begin
      pin_out_o <= pin_val_w;
      pin_oe_o  <= (state_nxt == ST_RUN) ? 4'hf : 4'h0; // [R4] [R19]
      irq_o     <= irq_r;
    end
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_sel_r <= `SPIRQ_PIN_SEL_RST;
      mask_r    <= `SPIRQ_MASK_RST;
      rdata_o   <= 32'h0000_0000;
    end else begin
      if (wr_i) begin
        if (addr_i == `SPIRQ_A_PIN_SEL) begin
          pin_sel_r <= wdata_i;
        end else if (addr_i == `SPIRQ_A_IRQ_MASK) begin
          mask_r <= wdata_i[`SPIRQ_NFLAG-1:0];
        end
      end
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        if (addr_i == `SPIRQ_A_PIN_SEL) begin
          rdata_o <= pin_sel_r;
        end else if (addr_i == `SPIRQ_A_IRQ_MASK) begin
          rdata_o <= {26'h0, mask_r};
        end else if (addr_i == `SPIRQ_A_STATUS) begin
          rdata_o <= {25'h0, irq_r, flag_s2_r}; // [R13]
        end else if (addr_i == `SPIRQ_A_IRQ_CAPTURE) begin
          rdata_o <= {26'h0, capture_r};
        end else if (addr_i == `SPIRQ_A_STRAP) begin
          rdata_o <= {28'h0, strap_r};
        end else if (addr_i == `SPIRQ_A_TUNING_WORD) begin
          rdata_o <= {16'h0, tuning_word_o};
        end else if (addr_i == `SPIRQ_A_SYSCLK) begin
          rdata_o <= {23'h0, loop_open_o, 1'b0, sysclk_direct_o, sysclk_mult_o};
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== spirq_regs.vh ====
// register offsets, field positions, reset values and timing counts for the status pin block
`ifndef SPIRQ_REGS_VH
`define SPIRQ_REGS_VH

// ------------------------------------------------------------
// register word addresses
// ------------------------------------------------------------
`define SPIRQ_ADDR_W          4
`define SPIRQ_A_PIN_SEL       4'h0
`define SPIRQ_A_IRQ_MASK      4'h1
`define SPIRQ_A_CONTROL       4'h2
`define SPIRQ_A_STATUS        4'h3
`define SPIRQ_A_IRQ_CAPTURE   4'h4
`define SPIRQ_A_STRAP         4'h5
`define SPIRQ_A_TUNING_WORD   4'h6
`define SPIRQ_A_SYSCLK        4'h7

// ------------------------------------------------------------
// field layout
// ------------------------------------------------------------
`define SPIRQ_NFLAG           6
`define SPIRQ_PIN_CFG_W       8
// per pin byte: [1:0] and [5:4] flag enables, [3:2] unused, [6] reference select, [7] interrupt mode
`define SPIRQ_CFG_REFSEL      6
`define SPIRQ_CFG_IRQMODE     7
// flag indices: [0] loss first, [1] out of limits first, [2] loss second,
// [3] out of limits second, [4] phase lock, [5] estimate done
`define SPIRQ_FLAG_EST_DONE   5
`define SPIRQ_CTRL_IRQ_RESET  0
`define SPIRQ_STRAP_W         4
`define SPIRQ_STRAP_SYSCLK    3
`define SPIRQ_TW_W            16
`define SPIRQ_MULT_W          6

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SPIRQ_PIN_SEL_RST     32'h0000_0000
`define SPIRQ_MASK_RST        6'h00
`define SPIRQ_MULT_DEFAULT    6'h28
`define SPIRQ_MULT_BYPASS     6'h00

// ------------------------------------------------------------
// timing: strap window of the reset pulse
// ------------------------------------------------------------
`define SPIRQ_CLK_PERIOD_NS   20
`define SPIRQ_POR_PULSE_NS    75
`define SPIRQ_POR_CYC         ((`SPIRQ_POR_PULSE_NS + `SPIRQ_CLK_PERIOD_NS - 1) / `SPIRQ_CLK_PERIOD_NS)
`define SPIRQ_CNT_W           3

`endif

// ==== spirq_tw_rom.v ====
// start-up tuning word table, eight 16-bit entries indexed by strap code
`timescale 1ns/1ns
`default_nettype none
`include "spirq_regs.vh"

module spirq_tw_rom (
  input  wire [2:0]               idx_i,
  output reg  [`SPIRQ_TW_W-1:0]   word_o
);

  // entry i scales inversely with the sample clock; values are codes for a 1 GHz clock
  always @* begin
    case (idx_i)
      3'h0:    word_o = 16'h0000;
      3'h1:    word_o = 16'h09f4;
      3'h2:    word_o = 16'h0d45;
      3'h3:    word_o = 16'h0fba;
      3'h4:    word_o = 16'h13e8;
      3'h5:    word_o = 16'h1797;
      3'h6:    word_o = 16'h1f75;
      default: word_o = 16'h27d0;
    endcase
  end

endmodule
`default_nettype wire

// ==== spirq_props.sv ====
// assertion checker for the status pin block
`timescale 1ns/1ns
`default_nettype none
module spirq_props (
  input wire        clock_i,
  input wire        arst_n_i,
  input wire        pin_rst_n_i,
  input wire [3:0]  pin_in_i,
  input wire [3:0]  pin_out_o,
  input wire [3:0]  pin_oe_o,
  input wire [5:0]  flags_i,
  input wire [3:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  input wire        irq_o,
  input wire [15:0] tuning_word_o,
  input wire        sysclk_direct_o,
  input wire [5:0]  sysclk_mult_o,
  input wire        loop_open_o
);
  // shadow of the pin select word, so pin outputs can be judged
  reg  [31:0] sel_r;
  wire        clr  = wr_i && addr_i == 4'h2 && wdata_i[0];
  wire [1:0]  ref1 = sel_r[14] ? flags_i[3:2] : flags_i[1:0];
  wire        p1   = |({ref1, flags_i[5:4]} & {sel_r[9:8], sel_r[13:12]});
  always @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i) sel_r <= 32'h0;
    else if (wr_i && addr_i == 4'h0) sel_r <= wdata_i;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside read cycle");
  AST_IRQ_HOLD: assert property (irq_o && !clr && !$past(clr) |=> irq_o)
    else $error("interrupt flag dropped without clear");
  // quiet flags for four cycles, so no event can race the clear
  AST_IRQ_CLEAR: assert property ($stable(flags_i)[*4] ##0 clr |=> ##1 !irq_o)
    else $error("interrupt flag not cleared");
  AST_OE_WINDOW: assert property ($rose(pin_oe_o[0]) |->
    pin_oe_o == 4'hf && $past(pin_oe_o, 4) == 4'h0)
    else $error("pin drivers returned too early or partly");
  AST_STRAP_CLK: assert property ($rose(pin_oe_o[0]) |->
    sysclk_direct_o == $past(pin_in_i[3]) && sysclk_mult_o == (sysclk_direct_o ? 6'h00 : 6'h28))
    else $error("clock source not taken from strap");
  AST_STRAP_ZERO: assert property ($rose(pin_oe_o[0]) && $past(pin_in_i[2:0]) == 3'h0 |->
    tuning_word_o == 16'h0)
    else $error("strap code zero gave nonzero tuning word");
  AST_PIN_FLOAT: assert property (!pin_rst_n_i[*4] |-> pin_oe_o == 4'h0)
    else $error("pins driven during pin reset");
  AST_PIN_IRQ: assert property (pin_oe_o[0] && sel_r[7] && $past(sel_r[7]) |->
    pin_out_o[0] == irq_o)
    else $error("interrupt pin differs from interrupt flag");
  AST_PIN_OR: assert property (($stable(flags_i) && $stable(sel_r))[*4] ##0
    (pin_oe_o[1] && $past(pin_oe_o[1]) && !sel_r[15]) |-> pin_out_o[1] == p1)
    else $error("status pin differs from selected flag combination");
endmodule
bind spirq_status_pins spirq_props spirq_props_i (.*);
`default_nettype wire

// ==== spirq_strap_board.sv ====
// board strap resistors on the four status pins
`timescale 1ns/1ns
`default_nettype none
module spirq_strap_board (
  input  wire [3:0] strap_i,
  input  wire [3:0] pin_out_i,
  input  wire [3:0] pin_oe_i,
  output wire [3:0] pin_o
);
  // an undriven pin settles to its resistor level
  assign pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & strap_i);
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the status pin block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clock_i = 0, arst_n_i = 0, pin_rst_n_i = 1, wr_i = 0, rd_i = 0;
  logic [3:0]  addr_i = 0, strap = 0, pin_in_i, pin_out_o, pin_oe_o;
  logic [31:0] wdata_i = 0, rdata_o;
  logic [5:0]  flags_i = 0, sysclk_mult_o;
  logic [15:0] tuning_word_o;
  logic        irq_o, sysclk_direct_o, loop_open_o;
  int          errors = 0, cmp_count = 0, cyc = 0;
  // start-up tuning words: listed start-up frequency over 1 GHz, times 2^16
  logic [15:0] tw_exp [8] = '{16'h0000, 16'h09f4, 16'h0d45, 16'h0fba,
                              16'h13e8, 16'h1797, 16'h1f75, 16'h27d0};
  always #10 clock_i = ~clock_i;
  spirq_status_pins spirq_status_pins_i (.*);
  spirq_strap_board spirq_strap_board_i (.strap_i(strap), .pin_out_i(pin_out_o),
    .pin_oe_i(pin_oe_o), .pin_o(pin_in_i));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      give_verdict;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge clock_i);
    wr_i <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge clock_i);
    rd_i <= 0;
    #1 chk(nm, e, rdata_o);
  endtask
  task automatic settle(input logic [5:0] f);
    @(posedge clock_i);
    flags_i <= f;
    repeat (6) @(posedge clock_i);
    #1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_strap(input logic [3:0] s, input bit by_pin);
    int n;
    @(posedge clock_i);
    strap <= s;
    if (by_pin) pin_rst_n_i <= 0;
    else arst_n_i <= 0;
    repeat (6) @(posedge clock_i);
    pin_rst_n_i <= 1;
    arst_n_i <= 1;
    #1 chk("float", 0, pin_oe_o);
    n = 0;
    while (pin_oe_o !== 4'hf && n < 20) begin
      @(posedge clock_i);
      #1 n++;
    end
    chk("pin_oe", 4'hf, pin_oe_o);
    chk("direct", s[3], sysclk_direct_o);
    chk("mult", s[3] ? 32'h0 : 32'h28, sysclk_mult_o);
    chk("loop_open", 1, loop_open_o);
    chk("tuning", tw_exp[s[2:0]], tuning_word_o);
    rd(4'h5, s, "strap reg");
  endtask
  task automatic t_pins;
    wr(4'h0, 32'h0030_4380);
    settle(6'h04);
    chk("pin1 second loss", 1, pin_out_o[1]);
    chk("pin2 idle", 0, pin_out_o[2]);
    settle(6'h01);
    chk("pin1 first loss", 0, pin_out_o[1]);
    settle(6'h10);
    chk("pin2 lock", 1, pin_out_o[2]);
    chk("pin3 none", 0, pin_out_o[3]);
    chk("irq masked", 0, irq_o);
    chk("pin0 irq", 0, pin_out_o[0]);
    rd(4'h3, 32'h10, "status");
    $display("test pins done");
  endtask
  task automatic t_irq;
    wr(4'h1, 32'h21);
    settle(6'h30);
    chk("irq est done", 1, irq_o);
    chk("pin0 irq", 1, pin_out_o[0]);
    rd(4'h4, 32'h30, "capture");
    wr(4'h2, 32'h1);
    settle(6'h30);
    chk("irq cleared", 0, irq_o);
    rd(4'h4, 32'h0, "capture cleared");
    settle(6'h10);
    chk("est done fall", 0, irq_o);
    settle(6'h11);
    chk("loss rise", 1, irq_o);
    settle(6'h10);
    chk("irq held", 1, irq_o);
    rd(4'h3, 32'h50, "status irq");
    wr(4'h2, 32'h1);
    settle(6'h12);
    chk("masked ool", 0, irq_o);
    rd(4'hf, 32'h0, "unmapped");
    $display("test irq done");
  endtask
  initial begin
    t_strap(4'h0, 0);
    for (int i = 1; i < 16; i++) t_strap(i[3:0], 1);
    $display("test strap done");
    t_pins;
    t_irq;
    give_verdict;
  end
endmodule
`default_nettype wire
